//--- verilog/scmc_pkg.sv
// Shared constants and carrier types of the system clock mode control.
// Assumes a 20 MHz core clock; oscillators are modelled as tick enables.
`default_nettype none
package scmc_pkg;
    // Core clock rate, used as the modulus of the tick accumulators
    localparam int CLK_KHZ = 20000;
    localparam int ACC_W = 16;
    localparam logic [15:0] RATE_MOD = 16'h4E20;
    localparam logic [15:0] INC_2MHZ = 16'h07D0;
    localparam logic [15:0] INC_4MHZ = 16'h0FA0;
    localparam logic [15:0] INC_8MHZ = 16'h1F40;
    localparam logic [15:0] INC_32KHZ = 16'h0020;
    // Fast oscillator settling time
    localparam int SETTLE_US = 10;
    localparam int SETTLE_CYC = (SETTLE_US * CLK_KHZ + 999) / 1000;
    localparam int SETTLE_W = 16;
    // Register byte addresses
    localparam int ADDR_W = 12;
    localparam logic [11:0] ADDR_SYS_CTRL = 12'h000;
    localparam logic [11:0] ADDR_OSC_CTRL = 12'h004;
    localparam logic [11:0] ADDR_MODE = 12'h008;
    // Field positions
    localparam int SEL_HI = 7;
    localparam int SEL_LO = 5;
    localparam int FKEEP_BIT = 1;
    localparam int SKEEP_BIT = 0;
    localparam int FREQ_HI = 3;
    localparam int FREQ_LO = 2;
    localparam int EN_BIT = 0;
    // Reset values
    localparam logic [2:0] SEL_RST = 3'h0;
    localparam logic [1:0] FREQ_RST = 2'h0;
    localparam logic EN_RST = 1'b1;
    // Codes
    localparam logic [2:0] SEL_SUB = 3'h7;
    localparam logic [1:0] FREQ_4M = 2'h1;
    localparam logic [1:0] FREQ_8M = 2'h2;
    localparam int DIV_W = 6;
    localparam logic [5:0] DIV_WRAP = 6'h3F;

    typedef enum logic [5:0] {
        ST_FAST = 6'h01,
        ST_SLOW = 6'h02,
        ST_SLEEP = 6'h04,
        ST_IDLE_SLOW_ONLY = 6'h08,
        ST_IDLE_DUAL_CLOCK = 6'h10,
        ST_IDLE_FAST_ONLY = 6'h20
    } scmc_state_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0] pwdata;
    } scmc_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } scmc_apb_rsp_t;

    typedef struct packed {
        logic sys;
        logic fast;
        logic sub;
        logic slow_osc;
    } scmc_clk_en_t;
endpackage
`default_nettype wire

//--- verilog/scmc_rate_gen.sv
// Tick generator standing in for an RC oscillator.
// Emits one-cycle enables at an average rate of inc/mod of the core clock.
`timescale 1ns/10ps
`default_nettype none
module scmc_rate_gen (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Control
    input wire logic run,
    input wire logic [scmc_pkg::ACC_W-1:0] inc,
    // Tick out
    output logic tick
);
    import scmc_pkg::*;
    logic [ACC_W-1:0] acc_ff;
    logic tick_ff;
    logic [ACC_W:0] sum;
    logic wrap;

    assign sum = {1'b0, acc_ff} + {1'b0, inc};
    assign wrap = sum >= {1'b0, RATE_MOD};
    assign tick = tick_ff;

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            acc_ff <= '0;
            tick_ff <= 1'b0;
        end
        else
        begin
            acc_ff <= !run ? '0 : wrap ? sum[ACC_W-1:0] - RATE_MOD : sum[ACC_W-1:0];
            tick_ff <= run && wrap;
        end
    end
endmodule // scmc_rate_gen
`default_nettype wire

//--- verilog/scmc_divider.sv
// Fast clock prescaler, ratios 1 to 64, plus the active source selection.
// A new selection is taken only when all ratios share an edge, so no runt.
`timescale 1ns/10ps
`default_nettype none
module scmc_divider (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Fast clock tick and requested selection
    input wire logic fast_tick,
    input wire logic [2:0] req_sel,
    // Divided tick and selection in force
    output logic div_tick,
    output logic [2:0] act_sel
);
    import scmc_pkg::*;
    logic [DIV_W-1:0] cnt_ff;
    logic [2:0] act_sel_ff;
    logic div_tick_ff;
    logic [DIV_W-1:0] mask;
    logic boundary;

    assign mask = ~(DIV_WRAP << act_sel_ff);
    assign boundary = fast_tick && (cnt_ff == DIV_WRAP);
    assign div_tick = div_tick_ff;
    assign act_sel = act_sel_ff;

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            cnt_ff <= '0;
            act_sel_ff <= SEL_RST;
            div_tick_ff <= 1'b0;
        end
        else
        begin
            cnt_ff <= cnt_ff + DIV_W'(fast_tick);
            div_tick_ff <= fast_tick && ((cnt_ff & mask) == mask);
            if (boundary)
            begin
                act_sel_ff <= req_sel;
            end
        end
    end
endmodule // scmc_divider
`default_nettype wire

//--- verilog/scmc_top.sv
// System clock mode control: APB registers, operating mode machine and
// clock enables for CPU, peripherals and watchdog.
// Assumes one 20 MHz clock; all derived clocks leave as one-cycle enables.
`timescale 1ns/10ps
`default_nettype none
module scmc_top #(
    parameter int SETTLE_CYCLES = scmc_pkg::SETTLE_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // APB slave
    input wire scmc_pkg::scmc_apb_req_t apb_req,
    output var scmc_pkg::scmc_apb_rsp_t apb_rsp,
    // CPU and watchdog
    input wire logic halt_req,
    input wire logic wake_req,
    input wire logic wdt_en,
    // Clock enables and status
    output var scmc_pkg::scmc_clk_en_t clk_en,
    output logic cpu_run,
    output var scmc_pkg::scmc_state_t mode
);
    import scmc_pkg::*;

    // Registers
    logic [2:0] sel_ff;
    logic fast_idle_keep_ff;
    logic slow_idle_keep_ff;
    logic [1:0] freq_ff;
    logic [1:0] freq_act_ff;
    logic en_ff;
    logic stable_ff;
    logic busy_ff;
    logic [SETTLE_W-1:0] settle_ff;
    logic osc_run_q_ff;
    scmc_state_t state_ff;
    scmc_state_t nxt_state;
    scmc_apb_rsp_t rsp_ff;
    scmc_clk_en_t clk_en_ff;
    scmc_clk_en_t nxt_clk_en;
    logic cpu_run_ff;

    // Bus decode
    logic setup;
    logic acc_done;
    logic hit_sys_ctrl;
    logic hit_osc_ctrl;
    logic hit_mode;
    logic hit_any;
    logic wr_sys_ctrl;
    logic wr_osc_ctrl;
    logic [7:0] sys_ctrl_rd;
    logic [7:0] osc_ctrl_rd;
    logic [7:0] mode_rd;
    logic [31:0] rd_data;
    logic [1:0] wr_freq;

    assign setup = apb_req.psel && !apb_req.penable;
    assign acc_done = apb_req.psel && apb_req.penable && rsp_ff.pready;
    assign hit_sys_ctrl = apb_req.paddr == ADDR_SYS_CTRL;
    assign hit_osc_ctrl = apb_req.paddr == ADDR_OSC_CTRL;
    assign hit_mode = apb_req.paddr == ADDR_MODE;
    assign hit_any = hit_sys_ctrl || hit_osc_ctrl || hit_mode;
    assign wr_sys_ctrl = acc_done && apb_req.pwrite && hit_sys_ctrl;
    assign wr_osc_ctrl = acc_done && apb_req.pwrite && hit_osc_ctrl;
    assign wr_freq = apb_req.pwdata[FREQ_HI:FREQ_LO];
    // Unimplemented bits read as zero
    assign sys_ctrl_rd = {sel_ff, 3'h0, fast_idle_keep_ff, slow_idle_keep_ff};
    assign osc_ctrl_rd = {4'h0, freq_ff, stable_ff, en_ff};
    assign mode_rd = {2'h0, state_ff};
    assign rd_data = hit_sys_ctrl ? {24'h00_0000, sys_ctrl_rd} :
                     hit_osc_ctrl ? {24'h00_0000, osc_ctrl_rd} :
                     hit_mode ? {24'h00_0000, mode_rd} : 32'h0000_0000;

    // Oscillators
    logic sel_sub;
    logic [2:0] act_sel;
    logic fast_tick;
    logic slow_tick;
    logic div_tick;
    logic osc_run;
    logic slow_run;
    logic restart;
    logic settle_done;
    logic [ACC_W-1:0] fast_inc;
    logic st_fast;
    logic st_sleep;
    logic st_idle_slow;
    logic st_idle_fast;

    assign st_fast = state_ff == ST_FAST;
    assign st_sleep = state_ff == ST_SLEEP;
    assign st_idle_slow = state_ff == ST_IDLE_SLOW_ONLY;
    assign st_idle_fast = state_ff == ST_IDLE_FAST_ONLY;
    assign sel_sub = act_sel == SEL_SUB;

    // Fast mode pins the oscillator on; the enable bit only stops it off it
    assign osc_run = (en_ff || st_fast) && !(st_sleep || st_idle_slow);
    // Slow oscillator always runs outside sleep; only a disabled watchdog with a clear slow keep bit lets sleep stop it
    assign slow_run = !st_sleep || wdt_en || slow_idle_keep_ff;
    assign restart = (osc_run && !osc_run_q_ff)
                     || (wr_osc_ctrl && osc_run && wr_freq != freq_ff);
    assign settle_done = busy_ff && settle_ff == '0;
    // Code 11 falls back to the lowest rate
    assign fast_inc = freq_act_ff == FREQ_4M ? INC_4MHZ :
                      freq_act_ff == FREQ_8M ? INC_8MHZ : INC_2MHZ;

    scmc_rate_gen u_fast_osc (
        .clk(clk),
        .reset(reset),
        .run(osc_run && stable_ff),
        .inc(fast_inc),
        .tick(fast_tick)
    );

    scmc_rate_gen u_slow_osc (
        .clk(clk),
        .reset(reset),
        .run(slow_run),
        .inc(INC_32KHZ),
        .tick(slow_tick)
    );

    scmc_divider u_div (
        .clk(clk),
        .reset(reset),
        .fast_tick(fast_tick),
        .req_sel(sel_ff),
        .div_tick(div_tick),
        .act_sel(act_sel)
    );

    // Mode machine
    scmc_state_t run_state;
    scmc_state_t halt_state;

    assign run_state = sel_sub ? ST_SLOW : ST_FAST;
    assign halt_state = fast_idle_keep_ff ?
                        (slow_idle_keep_ff ? ST_IDLE_DUAL_CLOCK : ST_IDLE_FAST_ONLY) :
                        (slow_idle_keep_ff ? ST_IDLE_SLOW_ONLY : ST_SLEEP);

    always_comb
    begin
        case (state_ff)
            ST_FAST, ST_SLOW:
            begin
                nxt_state = halt_req ? halt_state : run_state;
            end
            ST_SLEEP, ST_IDLE_SLOW_ONLY, ST_IDLE_DUAL_CLOCK, ST_IDLE_FAST_ONLY:
            begin
                nxt_state = wake_req ? run_state : state_ff;
            end
            default:
            begin
                nxt_state = ST_FAST;
            end
        endcase
    end

    // Clock gating per mode
    always_comb
    begin
        // Gated by the run condition too, so a tick already in flight cannot leak out
        nxt_clk_en.fast = fast_tick && osc_run;
        nxt_clk_en.sub = slow_tick && !(st_sleep || st_idle_fast);
        nxt_clk_en.slow_osc = slow_tick;
        case (state_ff)
            ST_FAST:
            begin
                nxt_clk_en.sys = div_tick;
            end
            ST_SLOW:
            begin
                nxt_clk_en.sys = slow_tick;
            end
            ST_IDLE_SLOW_ONLY:
            begin
                nxt_clk_en.sys = sel_sub && slow_tick;
            end
            ST_IDLE_DUAL_CLOCK:
            begin
                nxt_clk_en.sys = sel_sub ? slow_tick : div_tick;
            end
            ST_IDLE_FAST_ONLY:
            begin
                nxt_clk_en.sys = !sel_sub && div_tick;
            end
            default:
            begin
                nxt_clk_en.sys = 1'b0;
            end
        endcase
    end

    assign apb_rsp = rsp_ff;
    assign clk_en = clk_en_ff;
    assign cpu_run = cpu_run_ff;
    assign mode = state_ff;

    // Bus responder: one wait-free access cycle
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            rsp_ff <= '0;
        end
        else
        begin
            rsp_ff.pready <= setup;
            rsp_ff.pslverr <= setup && !hit_any;
            rsp_ff.prdata <= setup && !apb_req.pwrite ? rd_data : 32'h0000_0000;
        end
    end

    // Control registers
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            sel_ff <= SEL_RST;
            fast_idle_keep_ff <= 1'b0;
            slow_idle_keep_ff <= 1'b0;
            freq_ff <= FREQ_RST;
            en_ff <= EN_RST;
        end
        else if (wr_sys_ctrl)
        begin
            sel_ff <= apb_req.pwdata[SEL_HI:SEL_LO];
            fast_idle_keep_ff <= apb_req.pwdata[FKEEP_BIT];
            slow_idle_keep_ff <= apb_req.pwdata[SKEEP_BIT];
        end
        else if (wr_osc_ctrl)
        begin
            freq_ff <= wr_freq;
            en_ff <= apb_req.pwdata[EN_BIT];
        end
    end

    // Settling: fast ticks stop until the new frequency is stable, then it takes effect
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            settle_ff <= '0;
            busy_ff <= 1'b0;
            stable_ff <= 1'b0;
            osc_run_q_ff <= 1'b0;
            freq_act_ff <= FREQ_RST;
        end
        else
        begin
            osc_run_q_ff <= osc_run;
            if (!osc_run)
            begin
                busy_ff <= 1'b0;
                stable_ff <= 1'b0;
            end
            else if (restart)
            begin
                settle_ff <= SETTLE_W'(SETTLE_CYCLES - 1);
                busy_ff <= 1'b1;
                stable_ff <= 1'b0;
            end
            else if (settle_done)
            begin
                busy_ff <= 1'b0;
                stable_ff <= 1'b1;
                freq_act_ff <= freq_ff;
            end
            else if (busy_ff)
            begin
                settle_ff <= settle_ff - 1'b1;
            end
        end
    end

    // State and registered outputs
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            state_ff <= ST_FAST;
            clk_en_ff <= '0;
            cpu_run_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            clk_en_ff <= nxt_clk_en;
            cpu_run_ff <= nxt_state == ST_FAST || nxt_state == ST_SLOW;
        end
    end
endmodule // scmc_top
`default_nettype wire

//--- verif/scmc_top_sva.sv
// Port-level assertions for the clock mode control.
// Bound into every scmc_top; sees its ports only.
`timescale 1ns/10ps
`default_nettype none
module scmc_top_sva (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Watched ports
    input wire scmc_pkg::scmc_apb_req_t apb_req,
    input wire scmc_pkg::scmc_apb_rsp_t apb_rsp,
    input wire logic halt_req,
    input wire logic wake_req,
    input wire logic wdt_en,
    input wire scmc_pkg::scmc_clk_en_t clk_en,
    input wire logic cpu_run,
    input wire scmc_pkg::scmc_state_t mode
);
    import scmc_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    wire run_st = mode == ST_FAST || mode == ST_SLOW;
    wire setup = apb_req.psel && !apb_req.penable;
    wire bad_addr = !(apb_req.paddr inside {ADDR_SYS_CTRL, ADDR_OSC_CTRL, ADDR_MODE});
    sequence s_halt_taken;
        run_st && halt_req;
    endsequence
    // Ticks lag the state by a cycle, so look only after two steady cycles
    sequence s_parked(st);
        mode == st && $past(mode) == st && $past(mode, 2) == st;
    endsequence
    property p_cpu_run;
        $past(!reset) |-> cpu_run == run_st;
    endproperty
    property p_halt;
        s_halt_taken |=> !cpu_run && !run_st;
    endproperty
    property p_wake;
        !run_st && wake_req |=> mode inside {ST_FAST, ST_SLOW};
    endproperty
    property p_sleep;
        s_parked(ST_SLEEP) |-> !clk_en.sys && !clk_en.fast && !clk_en.sub;
    endproperty
    property p_slow_only;
        s_parked(ST_IDLE_SLOW_ONLY) |-> !clk_en.fast;
    endproperty
    property p_fast_only;
        s_parked(ST_IDLE_FAST_ONLY) |-> !clk_en.sub;
    endproperty
    property p_wdt_osc;
        mode == ST_SLEEP && wdt_en |-> ##[1:700] clk_en.slow_osc;
    endproperty
    property p_ready;
        setup |=> apb_rsp.pready;
    endproperty
    property p_unmapped;
        setup && bad_addr |=> apb_rsp.pslverr && apb_rsp.prdata == 32'h0000_0000;
    endproperty
    a_cpu_run: assert property (p_cpu_run) else $error("cpu_run disagrees with mode");
    a_halt: assert property (p_halt) else $error("halt not taken");
    a_wake: assert property (p_wake) else $error("wake not taken");
    a_sleep: assert property (p_sleep) else $error("clock ticks in sleep");
    a_slow_only: assert property (p_slow_only) else $error("fast tick in slow idle");
    a_fast_only: assert property (p_fast_only) else $error("sub tick in fast idle");
    a_wdt_osc: assert property (p_wdt_osc) else $error("slow osc stopped");
    a_ready: assert property (p_ready) else $error("no pready");
    a_unmapped: assert property (p_unmapped) else $error("no slave error");
endmodule // scmc_top_sva
bind scmc_top scmc_top_sva u_sva (
    .clk(clk), .reset(reset), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .halt_req(halt_req), .wake_req(wake_req), .wdt_en(wdt_en),
    .clk_en(clk_en), .cpu_run(cpu_run), .mode(mode)
);
`default_nettype wire

//--- verif/scmc_cpu_model.sv
// Stand-in for the CPU, peripherals and watchdog fed by the enables.
// Driven by the bench through its tasks; counts ticks on falling edges.
`timescale 1ns/10ps
`default_nettype none
module scmc_cpu_model (
    // Clock
    input wire logic clk,
    // Clock enables in
    input wire scmc_pkg::scmc_clk_en_t clk_en,
    // Requests out
    output logic halt_req,
    output logic wake_req,
    output logic wdt_en
);
    import scmc_pkg::*;
    initial
    begin
        halt_req = 1'b0;
        wake_req = 1'b0;
        wdt_en = 1'b1;
    end
    // One-cycle pulse, as a halt instruction or wake event gives
    task automatic pulse(input bit wake);
        @(posedge clk);
        halt_req <= !wake;
        wake_req <= wake;
        @(posedge clk);
        halt_req <= 1'b0;
        wake_req <= 1'b0;
    endtask
    // Watchdog enable level, changed just after an edge
    task automatic set_wdt(input bit on);
        @(posedge clk);
        wdt_en <= on;
    endtask
    // Ticks seen over a window: sys, fast, sub, slow osc
    task automatic count(input int cyc, output int n[4]);
        n = '{0, 0, 0, 0};
        repeat (cyc)
        begin
            @(negedge clk);
            n[0] += int'(clk_en.sys);
            n[1] += int'(clk_en.fast);
            n[2] += int'(clk_en.sub);
            n[3] += int'(clk_en.slow_osc);
        end
    endtask
endmodule // scmc_cpu_model
`default_nettype wire

//--- verif/scmc_top_test.sv
// Self-checking bench: APB register tasks, halt and wake via the CPU
// model, tick counts over fixed windows at 20 MHz.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) \
    begin \
        check_count++; \
        if ((g) !== (e)) \
        begin \
            num_errors++; \
            $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); \
        end \
    end
module scmc_top_test;
    import scmc_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    scmc_apb_req_t req = '0;
    scmc_apb_rsp_t rsp;
    scmc_clk_en_t ce;
    scmc_state_t mode;
    logic halt_req, wake_req, wdt_en, cpu_run, err;
    logic [31:0] rd;
    int num_errors = 0;
    int check_count = 0;
    int n[4];
    scmc_state_t mode_exp[4] = '{ST_SLEEP, ST_IDLE_SLOW_ONLY, ST_IDLE_FAST_ONLY, ST_IDLE_DUAL_CLOCK};
    logic [2:0] on_exp[4] = '{3'b000, 3'b001, 3'b110, 3'b111};
    logic [1:0] codes[4] = '{2'h1, 2'h3, 2'h0, 2'h2};
    int rate[4] = '{100, 200, 400, 100};
    always #25 clk = ~clk;
    scmc_top #(.SETTLE_CYCLES(4)) u_dut (.clk(clk), .reset(reset), .apb_req(req), .apb_rsp(rsp),
        .halt_req(halt_req), .wake_req(wake_req), .wdt_en(wdt_en), .clk_en(ce),
        .cpu_run(cpu_run), .mode(mode));
    scmc_cpu_model u_cpu (.clk(clk), .clk_en(ce), .halt_req(halt_req), .wake_req(wake_req),
        .wdt_en(wdt_en));
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{1'b1, 1'b0, w, a, {24'h0, d}};
        @(posedge clk);
        req.penable <= 1'b1;
        do @(posedge clk); while (rsp.pready !== 1'b1);
        rd = rsp.prdata;
        err = rsp.pslverr;
        req <= '0;
    endtask
    task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] e,
        input logic e_err);
        apb(1'b0, a, 8'h00);
        `CHK(nm, {e_err, e}, {err, rd})
    endtask
    // Divided ticks may land either side of a window edge
    function automatic logic near(input int got, input int exp);
        return got >= exp - 1 && got <= exp + 1;
    endfunction
    task automatic summarize();
        if (num_errors == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        #(60000 * 50);
        num_errors++;
        summarize();
    end
    initial
    begin
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        rdchk("osc_ctrl_rst", ADDR_OSC_CTRL, 32'h0000_0001, 1'b0);
        rdchk("sys_ctrl_rst", ADDR_SYS_CTRL, 32'h0000_0000, 1'b0);
        rdchk("unmapped", 12'h00C, 32'h0000_0000, 1'b1);
        rdchk("osc_ctrl_ok", ADDR_OSC_CTRL, 32'h0000_0003, 1'b0);
        apb(1'b1, ADDR_SYS_CTRL, 8'h1F);
        rdchk("sys_ctrl_bits", ADDR_SYS_CTRL, 32'h0000_0003, 1'b0);
        for (int i = 0; i < 4; i++)
        begin
            apb(1'b1, ADDR_OSC_CTRL, {4'h0, codes[i], 2'b01});
            rdchk("restart", ADDR_OSC_CTRL, {28'h0, codes[i], 2'b01}, 1'b0);
            repeat (20) @(posedge clk);
            rdchk("settled", ADDR_OSC_CTRL, {28'h0, codes[i], 2'b11}, 1'b0);
            u_cpu.count(1000, n);
            `CHK("fast_rate", 1'b1, near(n[1], rate[codes[i]]))
            `CHK("sys_rate", 1'b1, near(n[0], rate[codes[i]]))
        end
        for (int s = 1; s < 7; s++)
        begin
            apb(1'b1, ADDR_SYS_CTRL, {3'(s), 5'h00});
            repeat (200) @(posedge clk);
            u_cpu.count(3200, n);
            `CHK("div_rate", 1'b1, near(n[0], 1280 >> s))
            `CHK("fast_mode", ST_FAST, mode)
        end
        for (int k = 0; k < 4; k++)
        begin
            apb(1'b1, ADDR_SYS_CTRL, {6'h30, 2'(k)});
            u_cpu.pulse(1'b0);
            @(negedge clk);
            `CHK("idle_mode", mode_exp[k], mode)
            u_cpu.count(1300, n);
            `CHK("idle_clocks", on_exp[k], {n[0] > 0, n[1] > 0, n[2] > 0})
            `CHK("wdt_osc", 1'b1, n[3] > 0)
            u_cpu.pulse(1'b1);
            @(negedge clk);
            `CHK("woken", ST_FAST, mode)
        end
        apb(1'b1, ADDR_SYS_CTRL, 8'hE0);
        repeat (300) @(posedge clk);
        `CHK("slow_mode", ST_SLOW, mode)
        rdchk("mode_reg", ADDR_MODE, 32'h0000_0002, 1'b0);
        apb(1'b1, ADDR_OSC_CTRL, 8'h08);
        repeat (2) @(posedge clk);
        u_cpu.count(1300, n);
        `CHK("fast_off", 0, n[1])
        `CHK("sub_rate", 1'b1, near(n[2], 2))
        `CHK("sys_sub", 1'b1, near(n[0], n[2]))
        // Sleep with the watchdog off is the only case that stops the slow oscillator
        u_cpu.set_wdt(1'b0);
        u_cpu.pulse(1'b0);
        repeat (2) @(posedge clk);
        u_cpu.count(1300, n);
        `CHK("wdt_off_osc", 0, n[3])
        u_cpu.pulse(1'b1);
        @(negedge clk);
        `CHK("slow_back", ST_SLOW, mode)
        summarize();
    end
endmodule // scmc_top_test
`default_nettype wire
